// ===== sync_source_config_map.vh
// Register offsets, field positions, reset values and timing counts of the sync trigger.
`ifndef SYNC_SOURCE_CONFIG_MAP_VH
`define SYNC_SOURCE_CONFIG_MAP_VH

// ----------------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------------
`define ADDR_W 12
`define DATA_W 8
`define SAMPLE_W 16

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_NCO_CONTROL 12'h300
`define OFS_SYNC_SOURCE_CONFIG 12'h302
`define OFS_ACCUM_RESET_MASK 12'h303
`define OFS_SOFTWARE_SYNC_TRIGGER 12'h304
`define OFS_SELF_SYNC_CONTROL 12'h305
`define OFS_SYNC_STATUS 12'h306

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FAST_RECONFIG_BIT 7
`define TRIG_SEL_LSB 0
`define TRIG_SEL_MSB 1
`define MASK_LSB 0
`define MASK_MSB 3
`define SW_SYNC_BIT 0
`define SELF_RESYNC_BIT 0
`define STAT_SYSREF_ARMED_BIT 0
`define STAT_FAST_ARMED_BIT 1
`define STAT_PATTERN_ARMED_BIT 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_FAST_RECONFIG 1'h0
`define RST_TRIG_SEL 2'h0
`define RST_MASK 4'hf
`define RST_SW_SYNC 1'h0
`define RST_SELF_RESYNC 1'h0

// ----------------------------------------------------------------------------
// Trigger select codes
// ----------------------------------------------------------------------------
`define TRIG_SOFTWARE 2'h0
`define TRIG_SYSREF_ONCE 2'h1
`define TRIG_SYSREF_EVERY 2'h2
`define TRIG_PATTERN 2'h3

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
`define PATTERN_RUN 3'h4
`define SELF_RESYNC_PERIOD 9'h100
`define SELF_RESYNC_LAST 8'hff

`endif

// ===== edge_rise_sync.v
// Two-stage synchroniser with rising-edge detector for an asynchronous pin.
`timescale 1ns/10ps
module edge_rise_sync (
    input wire clk,  // Sample clock.
    input wire rst_b,  // Asynchronous reset, active low.
    input wire pin_in,  // Asynchronous pin level.
    input wire idle_level,  // Level assumed for the pin for the first two edges after reset.
    output wire level_out,  // Synchronised level.
    output wire rise_pulse  // One-cycle pulse on a rising edge.
);

    reg meta_ff;
    reg sync_ff;
    reg prev_ff;
    reg [1:0] idle_ff;

    // ------------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------------
    // The first stage feeds only the second stage.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= 1'h0;
            sync_ff <= 1'h0;
            prev_ff <= 1'h0;
            idle_ff <= 2'h0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            idle_ff <= {idle_ff[0], 1'h1};
            // The second stage holds real pin data only from the second edge
            // after reset, so the previous sample is the idle level until then.
            // Otherwise a pin that idles high would show a false edge.
            prev_ff <= idle_ff[1] ? sync_ff : idle_level;
        end
    end

    assign level_out = sync_ff;
    assign rise_pulse = idle_ff[1] & sync_ff & ~prev_ff;

endmodule

// ===== lsb_pattern_detect.v
// Detector for a run of low then high sample LSBs.
`timescale 1ns/10ps
`include "sync_source_config_map.vh"
module lsb_pattern_detect (
    input wire clk,  // Sample clock.
    input wire rst_b,  // Asynchronous reset, active low.
    input wire armed,  // Detector is searching.
    input wire lsb_in,  // LSB of the channel-zero in-phase sample.
    output wire hit  // High with the fourth high sample.
);

    reg [2:0] low_cnt_ff;
    reg [2:0] high_cnt_ff;
    reg [2:0] nxt_low_cnt;
    reg [2:0] nxt_high_cnt;

    wire low_done = (low_cnt_ff == `PATTERN_RUN);

    assign hit = armed & lsb_in & low_done & (high_cnt_ff == `PATTERN_RUN - 3'h1);

    // ------------------------------------------------------------------------
    // Run counters
    // ------------------------------------------------------------------------
    always @* begin
        nxt_low_cnt = low_cnt_ff;
        nxt_high_cnt = high_cnt_ff;
        if (!armed || hit) begin
            nxt_low_cnt = 3'h0;
            nxt_high_cnt = 3'h0;
        end else if (!lsb_in) begin
            // A low breaks any high run and starts or extends a low run.
            nxt_high_cnt = 3'h0;
            if (high_cnt_ff != 3'h0) begin
                nxt_low_cnt = 3'h1;
            end else if (!low_done) begin
                nxt_low_cnt = low_cnt_ff + 3'h1;
            end
        end else if (low_done) begin
            nxt_high_cnt = high_cnt_ff + 3'h1;
        end else begin
            nxt_low_cnt = 3'h0;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_ff <= 3'h0;
            high_cnt_ff <= 3'h0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            high_cnt_ff <= nxt_high_cnt;
        end
    end

endmodule

// ===== sync_source_config_event_trigger.v
// Sync event trigger for the four up-converter oscillators.
`timescale 1ns/10ps
`include "sync_source_config_map.vh"
module sync_source_config_event_trigger (
    input wire clk,  // Sample clock, 50 MHz.
    input wire rst_b,  // Asynchronous reset, active low.
    input wire [`ADDR_W-1:0] addr,  // Register address.
    input wire [`DATA_W-1:0] wdata,  // Register write data.
    input wire wr_stb,  // Register write strobe.
    input wire rd_stb,  // Register read strobe.
    output wire [`DATA_W-1:0] rdata,  // Read data, cycle after the strobe.
    input wire sysref_in,  // System reference pin, asynchronous.
    input wire fast_port_select_n,  // Fast-port chip select pin, asynchronous.
    input wire fast_sync_flag,  // Fast-path sync flag from the fast-port registers.
    input wire [3:0] fast_accum_reset_mask,  // Fast-path accumulator reset mask.
    input wire [`SAMPLE_W-1:0] sample_i_in,  // Channel-zero in-phase sample.
    output wire [`SAMPLE_W-1:0] sample_i_out,  // Sample towards the up-converter.
    output wire sync_event,  // One-cycle sync pulse to the oscillators.
    output wire [3:0] accum_reset,  // One-cycle accumulator reset per oscillator.
    output wire fast_reconfig_enable  // Oscillators take fast-path settings.
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg fast_reconfig_ff;
    reg [1:0] trig_sel_ff;
    reg [3:0] mask_ff;
    reg sw_sync_ff;
    reg self_resync_ff;
    reg [`DATA_W-1:0] rdata_ff;
    reg [`DATA_W-1:0] nxt_rdata;

    // ------------------------------------------------------------------------
    // Trigger state
    // ------------------------------------------------------------------------
    reg sysref_armed_ff;
    reg fast_armed_ff;
    reg [7:0] resync_cnt_ff;
    reg sync_event_ff;
    reg [3:0] accum_reset_ff;
    reg [`SAMPLE_W-1:0] sample_ff;

    wire sysref_rise;
    wire fast_cs_rise;
    wire pattern_hit;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function hit_addr;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] ofs;
        begin
            hit_addr = (a == ofs);
        end
    endfunction

    wire wr_ctrl = wr_stb & hit_addr(addr, `OFS_NCO_CONTROL);
    wire wr_src = wr_stb & hit_addr(addr, `OFS_SYNC_SOURCE_CONFIG);
    wire wr_mask = wr_stb & hit_addr(addr, `OFS_ACCUM_RESET_MASK);
    wire wr_sw = wr_stb & hit_addr(addr, `OFS_SOFTWARE_SYNC_TRIGGER);
    wire wr_self = wr_stb & hit_addr(addr, `OFS_SELF_SYNC_CONTROL);

    // A one written over a zero is the software edge; the fast path ignores it.
    wire sw_rise = wr_sw & wdata[`SW_SYNC_BIT] & ~sw_sync_ff & ~fast_reconfig_ff;
    wire sw_level = sw_sync_ff & ~fast_reconfig_ff;

    // ------------------------------------------------------------------------
    // Pin edge detectors
    // ------------------------------------------------------------------------
    edge_rise_sync u_sysref_edge (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in(sysref_in),
        .idle_level(1'h0),
        .level_out(),
        .rise_pulse(sysref_rise)
    );

    // The chip select idles high; a rise marks the end of a fast-port access.
    edge_rise_sync u_fast_cs_edge (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in(fast_port_select_n),
        .idle_level(1'h1),
        .level_out(),
        .rise_pulse(fast_cs_rise)
    );

    // ------------------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------------------
    wire mode_sw = (trig_sel_ff == `TRIG_SOFTWARE);
    wire mode_once = (trig_sel_ff == `TRIG_SYSREF_ONCE);
    wire mode_every = (trig_sel_ff == `TRIG_SYSREF_EVERY);
    wire mode_pat = (trig_sel_ff == `TRIG_PATTERN);

    // Normal path pattern search runs while the software bit is high;
    // the fast path searches from a flagged chip-select rise until a hit.
    wire pat_armed = mode_pat & (fast_reconfig_ff ? fast_armed_ff : sw_level);

    lsb_pattern_detect u_pattern (
        .clk(clk),
        .rst_b(rst_b),
        .armed(pat_armed),
        .lsb_in(sample_i_in[0]),
        .hit(pattern_hit)
    );

    wire sysref_fire = sysref_armed_ff & sysref_rise;
    wire fast_flag_rise = fast_reconfig_ff & fast_cs_rise & fast_sync_flag;
    wire resync_fire = self_resync_ff & (resync_cnt_ff == `SELF_RESYNC_LAST);

    reg trig_fire;
    always @* begin
        trig_fire = 1'h0;
        if (fast_reconfig_ff) begin
            // Selects 1 and 2 are reserved on the fast path and never fire.
            case (trig_sel_ff)
                `TRIG_SOFTWARE: trig_fire = fast_flag_rise;
                `TRIG_PATTERN: trig_fire = pattern_hit;
                default: trig_fire = 1'h0;
            endcase
        end else begin
            case (trig_sel_ff)
                `TRIG_SOFTWARE: trig_fire = sw_rise;
                `TRIG_SYSREF_ONCE: trig_fire = sysref_fire;
                `TRIG_SYSREF_EVERY: trig_fire = sw_level & sysref_rise;
                `TRIG_PATTERN: trig_fire = pattern_hit;
                default: trig_fire = 1'h0;
            endcase
        end
    end

    wire fire = trig_fire | resync_fire;

    // The mask picks the accumulators only on the normal path.
    wire [3:0] sel_mask = fast_reconfig_ff ? fast_accum_reset_mask : mask_ff;

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // The trigger select is only written while the host keeps the software
    // bit low and the fast port idle; no interlock is built here.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_reconfig_ff <= `RST_FAST_RECONFIG;
            trig_sel_ff <= `RST_TRIG_SEL;
            mask_ff <= `RST_MASK;
            sw_sync_ff <= `RST_SW_SYNC;
            self_resync_ff <= `RST_SELF_RESYNC;
        end else begin
            if (wr_ctrl) begin
                fast_reconfig_ff <= wdata[`FAST_RECONFIG_BIT];
            end
            if (wr_src) begin
                trig_sel_ff <= wdata[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
            end
            if (wr_mask) begin
                mask_ff <= wdata[`MASK_MSB:`MASK_LSB];
            end
            if (wr_sw) begin
                sw_sync_ff <= wdata[`SW_SYNC_BIT];
            end
            if (wr_self) begin
                self_resync_ff <= wdata[`SELF_RESYNC_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Arming and self-resync counter
    // ------------------------------------------------------------------------
    // A new arming that meets a firing edge in the same cycle waits for the
    // following edge, so an arm is never lost.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sysref_armed_ff <= 1'h0;
            fast_armed_ff <= 1'h0;
            resync_cnt_ff <= 8'h00;
        end else begin
            if (sw_rise & mode_once) begin
                sysref_armed_ff <= 1'h1;
            end else if (sysref_fire | fast_reconfig_ff) begin
                sysref_armed_ff <= 1'h0;
            end
            if (fast_flag_rise & mode_pat) begin
                fast_armed_ff <= 1'h1;
            end else if (pattern_hit | ~fast_reconfig_ff | ~mode_pat) begin
                fast_armed_ff <= 1'h0;
            end
            if (self_resync_ff) begin
                resync_cnt_ff <= resync_cnt_ff + 8'h01;
            end else begin
                resync_cnt_ff <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sync outputs and sample path
    // ------------------------------------------------------------------------
    // Sample and sync pulse both leave through one flop, so the pulse lines
    // up with the fourth high sample at the up-converter input.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_event_ff <= 1'h0;
            accum_reset_ff <= 4'h0;
            sample_ff <= 16'h0000;
        end else begin
            sync_event_ff <= fire;
            accum_reset_ff <= fire ? sel_mask : 4'h0;
            sample_ff[`SAMPLE_W-1:1] <= sample_i_in[`SAMPLE_W-1:1];
            sample_ff[0] <= sample_i_in[0] & ~(fast_reconfig_ff & fast_armed_ff);
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always @* begin
        nxt_rdata = 8'h00;
        case (addr)
            `OFS_NCO_CONTROL: nxt_rdata[`FAST_RECONFIG_BIT] = fast_reconfig_ff;
            `OFS_SYNC_SOURCE_CONFIG: nxt_rdata[`TRIG_SEL_MSB:`TRIG_SEL_LSB] = trig_sel_ff;
            `OFS_ACCUM_RESET_MASK: nxt_rdata[`MASK_MSB:`MASK_LSB] = mask_ff;
            `OFS_SOFTWARE_SYNC_TRIGGER: nxt_rdata[`SW_SYNC_BIT] = sw_sync_ff;
            `OFS_SELF_SYNC_CONTROL: nxt_rdata[`SELF_RESYNC_BIT] = self_resync_ff;
            `OFS_SYNC_STATUS: begin
                nxt_rdata[`STAT_SYSREF_ARMED_BIT] = sysref_armed_ff;
                nxt_rdata[`STAT_FAST_ARMED_BIT] = fast_armed_ff;
                nxt_rdata[`STAT_PATTERN_ARMED_BIT] = pat_armed;
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data stand for one cycle after each strobe cycle and are zero otherwise.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= rd_stb ? nxt_rdata : 8'h00;
        end
    end

    assign rdata = rdata_ff;
    assign sync_event = sync_event_ff;
    assign accum_reset = accum_reset_ff;
    assign sample_i_out = sample_ff;
    assign fast_reconfig_enable = fast_reconfig_ff;

endmodule

// ===== sync_source_config_sva.sv
// Assertions for the sync event trigger, bound to its ports.
`timescale 1ns/10ps
module sync_source_config_sva (
    input wire clk, // Clock.
    input wire rst_b, // Reset.
    input wire [11:0] addr, // Address.
    input wire [7:0] wdata, // Write data.
    input wire wr_stb, // Write strobe.
    input wire rd_stb, // Read strobe.
    input wire [7:0] rdata, // Read data.
    input wire [3:0] fast_accum_reset_mask, // Fast mask.
    input wire [15:0] sample_i_in, // Sample in.
    input wire [15:0] sample_i_out, // Sample out.
    input wire sync_event, // Sync pulse.
    input wire [3:0] accum_reset, // Resets.
    input wire fast_reconfig_enable // Fast mode.
);
    reg [1:0] sel_ff;
    reg [3:0] mask_ff;
    reg sw_ff;
    reg ss_ff;
    wire wr_sw = wr_stb && addr == 12'h304;
    // Shadows of the control registers other than the NCO control, rebuilt from the bus traffic.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_ff <= 2'h0;
            mask_ff <= 4'hf;
            sw_ff <= 1'b0;
            ss_ff <= 1'b0;
        end else if (wr_stb) begin
            if (addr == 12'h302) sel_ff <= wdata[1:0];
            if (addr == 12'h303) mask_ff <= wdata[3:0];
            if (addr == 12'h304) sw_ff <= wdata[0];
            if (addr == 12'h305) ss_ff <= wdata[0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sample_delay_a: assert property ($past(rst_b) && !fast_reconfig_enable
        |=> sample_i_out == $past(sample_i_in)) else $error("sample path wrong");
    fast_mode_a: assert property (wr_stb && addr == 12'h300
        |=> fast_reconfig_enable == $past(wdata[7])) else $error("fast enable wrong");
    sw_fire_a: assert property (wr_sw && wdata[0] && !sw_ff && sel_ff == 2'h0
        && !fast_reconfig_enable |=> sync_event) else $error("software sync missed");
    mask_normal_a: assert property (sync_event && !fast_reconfig_enable
        |-> accum_reset == mask_ff) else $error("reset mask wrong");
    mask_fast_a: assert property (sync_event && fast_reconfig_enable
        && $stable(fast_accum_reset_mask) |-> accum_reset == fast_accum_reset_mask)
        else $error("fast mask wrong");
    no_spurious_a: assert property (sync_event && !fast_reconfig_enable
        && sel_ff == 2'h0 && !ss_ff |-> $past(wr_sw && wdata[0] && !sw_ff))
        else $error("sync without cause");
    pattern_sync_a: assert property (sync_event && sel_ff == 2'h3
        && !fast_reconfig_enable && !ss_ff |-> sample_i_out[0] && $past(sample_i_out[0])
        && $past(sample_i_out[0], 2) && $past(sample_i_out[0], 3)
        && !$past(sample_i_out[0], 4) && !$past(sample_i_out[0], 5)
        && !$past(sample_i_out[0], 6) && !$past(sample_i_out[0], 7))
        else $error("pattern sync misplaced");
    fast_reserved_a: assert property (fast_reconfig_enable && !ss_ff
        && (sel_ff == 2'h1 || sel_ff == 2'h2) |-> !sync_event) else $error("reserved fired");
    sw_readback_a: assert property (rd_stb && addr == 12'h304
        |=> rdata == {7'h00, sw_ff}) else $error("sync bit readback wrong");
endmodule
bind sync_source_config_event_trigger sync_source_config_sva chk (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fast_accum_reset_mask(fast_accum_reset_mask), .sample_i_in(sample_i_in),
    .sample_i_out(sample_i_out), .sync_event(sync_event), .accum_reset(accum_reset),
    .fast_reconfig_enable(fast_reconfig_enable));

// ===== host_stream.sv
// Host-side model of the sample stream and the two pins.
`timescale 1ns/10ps
module host_stream (
    input wire clk, // Clock.
    input wire rst_b, // Reset.
    input wire pat_go, // Start an LSB run.
    input wire [2:0] pat_lows, // Lows before four highs.
    input wire pin_go, // Pulse both pins.
    output wire [15:0] sample_i_in, // Sample stream.
    output wire sysref_in, // Reference pin.
    output wire fast_port_select_n // Chip select pin.
);
    reg [3:0] step_ff;
    reg [2:0] pin_ff;
    reg [14:0] count_ff;
    // Idle LSB is high, so only a commanded run can form the trigger.
    assign sample_i_in = {count_ff, step_ff < 4'h5};
    assign sysref_in = pin_ff != 3'h0;
    assign fast_port_select_n = pin_ff == 3'h0;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_ff <= 4'h0;
            pin_ff <= 3'h0;
            count_ff <= 15'h0000;
        end else begin
            count_ff <= count_ff + 15'h0001;
            if (pat_go) step_ff <= {1'b0, pat_lows} + 4'h4;
            else if (step_ff != 4'h0) step_ff <= step_ff - 4'h1;
            if (pin_go) pin_ff <= 3'h4;
            else if (pin_ff != 3'h0) pin_ff <= pin_ff - 3'h1;
        end
    end
endmodule

// ===== sync_source_config_event_trigger_tb.sv
// Self-checking testbench for the sync event trigger.
`timescale 1ns/10ps
module sync_source_config_event_trigger_tb;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [11:0] addr = 12'h000;
    reg [7:0] wdata = 8'h00;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg fast_sync_flag = 1'b0;
    reg [3:0] fast_accum_reset_mask = 4'h6;
    reg pat_go = 1'b0;
    reg [2:0] pat_lows = 3'h4;
    reg pin_go = 1'b0;
    reg [3:0] last_mask = 4'h0;
    wire [7:0] rdata;
    wire [15:0] sample_i_in;
    wire [15:0] sample_i_out;
    wire [3:0] accum_reset;
    wire sysref_in;
    wire fast_port_select_n;
    wire sync_event;
    wire fast_reconfig_enable;
    integer fail_count = 0;
    integer compares = 0;
    integer syncs = 0;
    integer ones = 0;
    integer base = 0;
    integer bones = 0;
    always #10 clk = ~clk;
    sync_source_config_event_trigger dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sysref_in(sysref_in),
        .fast_port_select_n(fast_port_select_n), .fast_sync_flag(fast_sync_flag),
        .fast_accum_reset_mask(fast_accum_reset_mask), .sample_i_in(sample_i_in),
        .sample_i_out(sample_i_out), .sync_event(sync_event), .accum_reset(accum_reset),
        .fast_reconfig_enable(fast_reconfig_enable));
    host_stream host (.clk(clk), .rst_b(rst_b), .pat_go(pat_go), .pat_lows(pat_lows),
        .pin_go(pin_go), .sample_i_in(sample_i_in), .sysref_in(sysref_in),
        .fast_port_select_n(fast_port_select_n));
    // Counters sample the settled outputs at each edge.
    always @(posedge clk) begin
        if (sync_event === 1'b1) syncs <= syncs + 1;
        if (sync_event === 1'b1) last_mask <= accum_reset;
        if (sample_i_out[0] === 1'b1) ones <= ones + 1;
    end
    // ----
    // Bus and check tasks
    // ----
    task check(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr_stb <= 1'b1;
            @(posedge clk);
            wr_stb <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [11:0] a, input [7:0] exp);
        begin
            addr <= a;
            rd_stb <= 1'b1;
            @(posedge clk);
            rd_stb <= 1'b0;
            #1;
            check({8'h00, rdata}, {8'h00, exp});
            @(posedge clk);
        end
    endtask
    task mark;
        begin
            base = syncs;
            bones = ones;
        end
    endtask
    task settle(input integer n, input integer want);
        begin
            repeat (n) @(posedge clk);
            check(16'(syncs - base), 16'(want));
        end
    endtask
    task pins;
        begin
            pin_go <= 1'b1;
            @(posedge clk);
            pin_go <= 1'b0;
            @(posedge clk);
        end
    endtask
    task pat(input [2:0] n);
        begin
            pat_lows <= n;
            pat_go <= 1'b1;
            @(posedge clk);
            pat_go <= 1'b0;
            @(posedge clk);
        end
    endtask
    task complete_run;
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(12'h300, 8'h00);
        rd(12'h302, 8'h00);
        rd(12'h303, 8'h0f);
        rd(12'h304, 8'h00);
        rd(12'h305, 8'h00);
        rd(12'h3ff, 8'h00);
        wr(12'h302, 8'hff);
        rd(12'h302, 8'h03);
        wr(12'h302, 8'h00);
        $display("register test done");
        wr(12'h303, 8'h05);
        mark;
        wr(12'h304, 8'h01);
        settle(4, 1);
        check({12'h000, last_mask}, 16'h0005);
        mark;
        wr(12'h304, 8'h01);
        wr(12'h304, 8'h00);
        settle(4, 0);
        mark;
        wr(12'h304, 8'h01);
        settle(4, 1);
        rd(12'h304, 8'h01);
        wr(12'h304, 8'h00);
        $display("software test done");
        wr(12'h302, 8'h01);
        mark;
        wr(12'h304, 8'h01);
        settle(8, 0);
        mark;
        pins;
        settle(12, 1);
        mark;
        pins;
        settle(12, 0);
        wr(12'h304, 8'h00);
        $display("sysref once test done");
        wr(12'h302, 8'h02);
        wr(12'h304, 8'h01);
        mark;
        pins;
        settle(10, 1);
        mark;
        pins;
        settle(10, 1);
        wr(12'h304, 8'h00);
        mark;
        pins;
        settle(10, 0);
        $display("sysref every test done");
        wr(12'h302, 8'h03);
        wr(12'h304, 8'h01);
        mark;
        pat(3'h3);
        settle(20, 0);
        mark;
        pat(3'h4);
        settle(20, 1);
        wr(12'h304, 8'h00);
        $display("pattern test done");
        wr(12'h300, 8'h80);
        wr(12'h302, 8'h00);
        fast_sync_flag <= 1'b1;
        mark;
        pins;
        settle(16, 1);
        check({12'h000, last_mask}, 16'h0006);
        wr(12'h302, 8'h01);
        mark;
        pins;
        settle(16, 0);
        wr(12'h302, 8'h02);
        mark;
        pins;
        settle(16, 0);
        wr(12'h302, 8'h00);
        mark;
        wr(12'h304, 8'h01);
        settle(8, 0);
        wr(12'h304, 8'h00);
        fast_sync_flag <= 1'b0;
        mark;
        pins;
        settle(16, 0);
        fast_sync_flag <= 1'b1;
        $display("fast test done");
        wr(12'h302, 8'h03);
        mark;
        pins;
        settle(12, 0);
        mark;
        settle(8, 0);
        check(16'(ones - bones), 16'h0000);
        mark;
        pat(3'h5);
        settle(20, 1);
        check(16'(ones - bones != 0), 16'h0001);
        wr(12'h300, 8'h00);
        $display("fast pattern test done");
        wr(12'h302, 8'h00);
        mark;
        wr(12'h305, 8'h01);
        settle(600, 2);
        check({12'h000, last_mask}, 16'h0005);
        wr(12'h305, 8'h00);
        mark;
        settle(300, 0);
        $display("self resync test done");
        complete_run;
    end
endmodule
